// ---- burst_sram_map.svh ----
// constants of the burst-of-two sram link
`ifndef BURST_SRAM_MAP_SVH
`define BURST_SRAM_MAP_SVH
`define WORD_W     18
`define LANE_W     9
`define LANES      2
`define CLK_NS     8
`define LOCK_US    20
`define LOCK_CYC   ((`LOCK_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`define STOP_NS    30
`define STOP_CYC   ((`STOP_NS + `CLK_NS - 1) / `CLK_NS)
`define STOP_SEEN  16
`define STOP_HOLD  64
`define ZQ_PERIOD  1024
`define K_HALF     4
`define MASK_NONE  2'h3
`endif

// ---- burst_sram_pkg.sv ----
// types shared by both ends of the burst sram link
package burst_sram_pkg;
  typedef logic [17:0] word_t;
  typedef enum {OUT_IDLE, OUT_LO, OUT_HI} out_phase_e;
endpackage

// ---- burst_sram_if.sv ----
// link between memory controller and burst sram
`timescale 1ns/1ns
`default_nettype none
interface burst_sram_if #(parameter int ADDR_W = 8);
  logic              k;
  logic              k_n;
  logic              c;
  logic              c_n;
  logic              read_port_select_n;
  logic              write_port_select_n;
  logic              loop_disable_n;
  logic [1:0]        byte_lane_write_mask_n;
  logic [ADDR_W-1:0] addr;
  logic [17:0]       d;
  logic [17:0]       q;
  logic              q_oe_n;
  logic              returned_strobe;
  logic              returned_strobe_n;
  logic              loop_locked;
  wire  [17:0]       q_bus;
  // an undriven read bus shows the inverse of the last word, so a stale capture shows up
  assign q_bus = q_oe_n ? ~q : q;
  modport dev (
    input  k, k_n, c, c_n, read_port_select_n, write_port_select_n, loop_disable_n,
    input  byte_lane_write_mask_n, addr, d,
    output q, q_oe_n, returned_strobe, returned_strobe_n, loop_locked
  );
  modport host (
    output k, k_n, c, c_n, read_port_select_n, write_port_select_n, loop_disable_n,
    output byte_lane_write_mask_n, addr, d,
    input  q_bus, q_oe_n, returned_strobe, returned_strobe_n, loop_locked
  );
endinterface
`default_nettype wire

// ---- sram_device_end.sv ----
// device end: burst-of-two sram with separate read and write ports
// Operation
// - every access moves two 18-bit words
// - read select low at k rise starts read
// - words on c_n rise t+1, c rise t+2
// - loop on: data 1.5 cycles after address
// - outputs float after next output clock rise
// - write select at k rise takes word0
// - k_n rise takes address, word1, commits
// - deselected write port finishes, then ignores inputs
// - low byte mask writes lane, high keeps
// - strapped c pair high: k pair clocks outputs
// - single clock choice fixed at reset
// - read and write ports run independently
// - same location returns newest data
// - forward write begun previous k rise
// - port selects sampled only at k rise
// - deselect spares other port, pending completes
// - impedance update every 1024 clock cycles
// - two free-running echo clocks
// - lock reported 20 us after stable clock
// - controller stops clock 30 ns to relock; this end counts a stop only after 16 cycles (128 ns) with no k pair rise
// - loop disabled: one cycle read latency
`include "burst_sram_map.svh"
`timescale 1ns/1ns
`default_nettype none
module sram_device_end
  import burst_sram_pkg::*;
#(
  parameter int ADDR_W    = 8,
  parameter int STOP_SEEN = `STOP_SEEN
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // link to controller
  burst_sram_if.dev link,
  // status
  output logic      impedance_update,
  output logic      single_clock_mode
);
  localparam int IW   = 9 + ADDR_W + `WORD_W;
  localparam int ZQ_W = $clog2(`ZQ_PERIOD);
  localparam int LK_W = $clog2(`LOCK_CYC + 1);
  localparam int ID_W = $clog2(STOP_SEEN + 1);

  // merge a new word into a stored one lane by lane
  function automatic word_t merge(word_t old, word_t nw, logic [1:0] m_n);
    word_t r;
    r = old;
    for (int b = 0; b < `LANES; b++) begin
      if (!m_n[b]) begin
        r[b*`LANE_W +: `LANE_W] = nw[b*`LANE_W +: `LANE_W];
      end
    end
    return r;
  endfunction

  // every link input is a pin from another domain
  logic [IW-1:0]     s1;
  logic [IW-1:0]     s2;
  logic              k_s;
  logic              kn_s;
  logic              c_s;
  logic              cn_s;
  logic              rps_s;
  logic              wps_s;
  logic              dis_s;
  logic [1:0]        mask_s;
  logic [ADDR_W-1:0] addr_s;
  word_t             d_s;

  always_ff @(posedge mclk) begin
    s1 <= {link.k, link.k_n, link.c, link.c_n, link.read_port_select_n,
           link.write_port_select_n, link.loop_disable_n,
           link.byte_lane_write_mask_n, link.addr, link.d};
    s2 <= s1;
  end
  assign {k_s, kn_s, c_s, cn_s, rps_s, wps_s, dis_s, mask_s, addr_s, d_s} = s2;

  // straps are caught once, on the first cycle after reset release
  logic strap_done;
  logic legacy;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      strap_done        <= 1'b0;
      single_clock_mode <= 1'b0;
      legacy            <= 1'b0;
    end else if (!strap_done) begin
      strap_done        <= 1'b1;
      single_clock_mode <= c_s & cn_s;
      legacy            <= !dis_s;
    end
  end

  // edge detection on the input and output clock pairs
  wire       oc   = single_clock_mode ? k_s : c_s;
  wire       ocn  = single_clock_mode ? kn_s : cn_s;
  wire [3:0] cur  = {k_s, kn_s, oc, ocn};
  logic [3:0] prev;
  always_ff @(posedge mclk) begin
    prev <= cur;
  end
  wire rise_k  = strap_done & cur[3] & !prev[3];
  wire rise_kn = strap_done & cur[2] & !prev[2];
  wire rise_c  = strap_done & cur[1] & !prev[1];
  wire rise_cn = strap_done & cur[0] & !prev[0];

  // array holds base word at even index, base plus one at odd
  word_t mem [2**(ADDR_W+1)];

  // write port
  logic              wr_pend;
  word_t             w0;
  logic [1:0]        m0;
  wire [ADDR_W:0]    wa0 = {addr_s, 1'b0};
  wire [ADDR_W:0]    wa1 = {addr_s, 1'b1};
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
    end else if (rise_k) begin
      wr_pend <= !wps_s;
    end else if (rise_kn) begin
      wr_pend <= 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (rise_k) begin
      w0 <= d_s;
      m0 <= mask_s;
    end
    if (rise_kn && wr_pend) begin
      mem[wa0] <= merge(mem[wa0], w0, m0);
      mem[wa1] <= merge(mem[wa1], d_s, mask_s);
    end
  end

  // read port: stage 1 is the read begun at the latest k rise
  logic              rd_v1;
  logic              rd_v2;
  logic [ADDR_W-1:0] rd_a1;
  logic [ADDR_W-1:0] rd_a2;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_v1 <= 1'b0;
      rd_v2 <= 1'b0;
    end else if (rise_k) begin
      rd_v1 <= !rps_s;
      rd_v2 <= rd_v1;
    end
  end
  always_ff @(posedge mclk) begin
    if (rise_k) begin
      rd_a1 <= addr_s;
      rd_a2 <= rd_a1;
    end
  end

  // with the loop off the first word leaves on c, a half cycle early
  wire              first_ev  = legacy ? rise_c : rise_cn;
  wire              second_ev = legacy ? rise_cn : rise_c;
  wire              first_v   = legacy ? rd_v1 : rd_v2;
  wire [ADDR_W-1:0] first_a   = legacy ? rd_a1 : rd_a2;
  // the array is read at drive time, so every committed write is seen
  wire word_t       rd_lo     = mem[{first_a, 1'b0}];
  logic [ADDR_W-1:0] oaddr;
  wire word_t       rd_hi     = mem[{oaddr, 1'b1}];
  out_phase_e       ost;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ost         <= OUT_IDLE;
      link.q_oe_n <= 1'b1;
      link.q      <= 18'h00000;
      oaddr       <= '0;
    end else if (first_ev) begin
      if (first_v) begin
        link.q      <= rd_lo;
        link.q_oe_n <= 1'b0;
        oaddr       <= first_a;
        ost         <= OUT_LO;
      end else if (ost == OUT_HI) begin
        link.q_oe_n <= 1'b1;
        ost         <= OUT_IDLE;
      end
    end else if (second_ev) begin
      case (ost)
        OUT_LO: begin
          link.q <= rd_hi;
          ost    <= OUT_HI;
        end
        OUT_HI: begin
          link.q_oe_n <= 1'b1;
          ost         <= OUT_IDLE;
        end
        default: ost <= OUT_IDLE;
      endcase
    end
  end

  // echo clocks follow the output clock pair, never gated
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      link.returned_strobe   <= 1'b0;
      link.returned_strobe_n <= 1'b0;
    end else begin
      link.returned_strobe   <= oc;
      link.returned_strobe_n <= ocn;
    end
  end

  // impedance update paced by input clock cycles
  logic [ZQ_W-1:0] zq_cnt;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      zq_cnt           <= '0;
      impedance_update <= 1'b0;
    end else begin
      impedance_update <= rise_k && (zq_cnt == ZQ_W'(`ZQ_PERIOD - 1));
      if (rise_k) begin
        zq_cnt <= zq_cnt + 1'b1;
      end
    end
  end

  // lock: a k pair silent for STOP_SEEN cycles counts as stopped
  logic [ID_W-1:0] idle;
  logic [LK_W-1:0] lk_cnt;
  wire             stopped = idle >= ID_W'(STOP_SEEN);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      idle <= '0;
    end else if (rise_k || rise_kn) begin
      idle <= '0;
    end else if (!stopped) begin
      idle <= idle + 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n || !strap_done) begin
      lk_cnt           <= '0;
      link.loop_locked <= 1'b0;
    end else if (legacy) begin
      link.loop_locked <= 1'b1;
    end else if (stopped) begin
      lk_cnt           <= '0;
      link.loop_locked <= 1'b0;
    end else if (lk_cnt == LK_W'(`LOCK_CYC - 1)) begin
      link.loop_locked <= 1'b1;
    end else begin
      lk_cnt <= lk_cnt + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- sram_host_end.sv ----
// controller end: makes the clock pairs and issues burst reads and writes
`include "burst_sram_map.svh"
`timescale 1ns/1ns
`default_nettype none
module sram_host_end
  import burst_sram_pkg::*;
#(
  parameter int ADDR_W       = 8,
  parameter int K_HALF       = `K_HALF,
  parameter int STOP_HOLD    = `STOP_HOLD,
  parameter bit SINGLE_CLOCK = 1'b0,
  parameter bit LOOP_ON      = 1'b1
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // link to device
  burst_sram_if.host             link,
  // read requests
  input  wire logic              rd_req,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic                   rd_ready,
  output logic                   rd_valid,
  output logic [35:0]            rd_data,
  // write requests
  input  wire logic              wr_req,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [35:0]       wr_data,
  input  wire logic [3:0]        wr_mask_n,
  output logic                   wr_ready,
  // loop control
  input  wire logic              loop_restart
);
  localparam int PH_W = $clog2(2 * K_HALF);
  localparam int SH_W = $clog2(STOP_HOLD + 1);
  // the stop must cover the device's least relock stop time
  localparam int HOLD = (STOP_HOLD > `STOP_CYC) ? STOP_HOLD : `STOP_CYC;

  logic [PH_W-1:0] ph;
  logic [SH_W-1:0] stop_cnt;
  wire             halted  = stop_cnt != '0;
  wire             launch  = !halted && ph == PH_W'(K_HALF + K_HALF / 2);
  wire             second  = !halted && ph == PH_W'(K_HALF / 2);
  wire             ph_wrap = ph == PH_W'(2 * K_HALF - 1);
  wire             k_next  = halted || ph < PH_W'(K_HALF);
  wire             kn_next = halted || ph >= PH_W'(K_HALF);

  // clock divider; both clocks rest high while stopped
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ph       <= '0;
      stop_cnt <= '0;
      link.k   <= 1'b1;
      link.k_n <= 1'b1;
      link.c   <= 1'b1;
      // straps are read as reset ends, so the reset levels must already match the mode
      link.c_n <= SINGLE_CLOCK;
      link.loop_disable_n <= LOOP_ON;
    end else begin
      if (loop_restart) begin
        stop_cnt <= SH_W'(HOLD);
      end else if (halted) begin
        stop_cnt <= stop_cnt - 1'b1;
      end
      ph       <= (halted || ph_wrap) ? '0 : ph + 1'b1;
      link.k   <= k_next;
      link.k_n <= kn_next;
      link.c   <= SINGLE_CLOCK ? 1'b1 : k_next;
      link.c_n <= SINGLE_CLOCK ? 1'b1 : kn_next;
      link.loop_disable_n <= LOOP_ON;
    end
  end

  // device outputs are another domain
  logic [21:0] r1;
  logic [21:0] r2;
  always_ff @(posedge mclk) begin
    r1 <= {link.returned_strobe, link.returned_strobe_n, link.q_oe_n,
           link.loop_locked, link.q_bus};
    r2 <= r1;
  end
  wire   rs_s     = r2[21];
  wire   rsn_s    = r2[20];
  wire   oe_n_s   = r2[19];
  wire   locked_s = r2[18];
  wire word_t q_s = r2[17:0];

  // one pending read and one pending write
  logic              rslot;
  logic              wslot;
  logic [ADDR_W-1:0] raddr;
  logic [ADDR_W-1:0] waddr;
  logic [35:0]       wdata;
  logic [3:0]        wmask;
  logic [ADDR_W-1:0] hi_addr;
  word_t             hi_d;
  logic [1:0]        hi_m;
  wire               rtake = rd_req && rd_ready;
  wire               wtake = wr_req && wr_ready;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rslot    <= 1'b0;
      wslot    <= 1'b0;
      rd_ready <= 1'b0;
      wr_ready <= 1'b0;
    end else begin
      rslot    <= rtake || (rslot && !launch);
      wslot    <= wtake || (wslot && !launch);
      rd_ready <= locked_s && !rtake && !(rslot && !launch);
      wr_ready <= locked_s && !wtake && !(wslot && !launch);
    end
  end
  always_ff @(posedge mclk) begin
    if (rtake) begin
      raddr <= rd_addr;
    end
    if (wtake) begin
      waddr <= wr_addr;
      wdata <= wr_data;
      wmask <= wr_mask_n;
    end
  end

  // pins change mid half-cycle so both edges see settled values
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      link.read_port_select_n     <= 1'b1;
      link.write_port_select_n    <= 1'b1;
      link.addr                   <= '0;
      link.d                      <= 18'h00000;
      link.byte_lane_write_mask_n <= `MASK_NONE;
      hi_addr <= '0;
      hi_d    <= 18'h00000;
      hi_m    <= `MASK_NONE;
    end else if (launch) begin
      link.read_port_select_n     <= !rslot;
      link.write_port_select_n    <= !wslot;
      link.addr                   <= raddr;
      link.d                      <= wdata[17:0];
      link.byte_lane_write_mask_n <= wslot ? wmask[1:0] : `MASK_NONE;
      hi_addr <= waddr;
      hi_d    <= wdata[35:18];
      hi_m    <= wslot ? wmask[3:2] : `MASK_NONE;
    end else if (second) begin
      link.read_port_select_n     <= 1'b1;
      link.write_port_select_n    <= 1'b1;
      link.addr                   <= hi_addr;
      link.d                      <= hi_d;
      link.byte_lane_write_mask_n <= hi_m;
    end
  end

  // read capture on the echo clocks; word order follows the loop mode
  logic  rs_q;
  logic  rsn_q;
  logic  have_lo;
  word_t lo;
  wire   first_rise  = LOOP_ON ? (rsn_s && !rsn_q) : (rs_s && !rs_q);
  wire   second_rise = LOOP_ON ? (rs_s && !rs_q) : (rsn_s && !rsn_q);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rs_q     <= 1'b0;
      rsn_q    <= 1'b0;
      have_lo  <= 1'b0;
      lo       <= 18'h00000;
      rd_valid <= 1'b0;
      rd_data  <= 36'h000000000;
    end else begin
      rs_q     <= rs_s;
      rsn_q    <= rsn_s;
      rd_valid <= 1'b0;
      if (first_rise && !oe_n_s) begin
        lo      <= q_s;
        have_lo <= 1'b1;
      end else if (second_rise && have_lo) begin
        rd_data  <= {q_s, lo};
        rd_valid <= 1'b1;
        have_lo  <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- burst_sram_chk.sv ----
// concurrent checks on the link between the two burst sram ends
`include "burst_sram_map.svh"
`timescale 1ns/1ns
`default_nettype none
module burst_sram_chk #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic              mclk,
  input wire logic              rst_n,
  // link
  input wire logic              k,
  input wire logic              k_n,
  input wire logic              c,
  input wire logic              read_port_select_n,
  input wire logic              write_port_select_n,
  input wire logic              loop_disable_n,
  input wire logic [1:0]        byte_lane_write_mask_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [17:0]       d,
  input wire logic              q_oe_n,
  input wire logic              returned_strobe,
  input wire logic              loop_locked
);
  localparam int LOCK_LATE = `LOCK_CYC + 200;
  logic [5:0]  rd_gap;
  logic [11:0] lock_cnt;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // idle time of the read port; a read only counts as isolated after a long gap
  always_ff @(posedge mclk) begin
    if (!rst_n || !read_port_select_n) rd_gap <= '0;
    else if (rd_gap != 6'h3f) rd_gap <= rd_gap + 6'h01;
  end
  always_ff @(posedge mclk) begin
    if (!rst_n || loop_locked) lock_cnt <= '0;
    else if (lock_cnt != 12'hfff) lock_cnt <= lock_cnt + 12'h001;
  end

  rd_sel_hold_a: assert property ($fell(read_port_select_n) |-> !read_port_select_n [*3])
    else $error("read select released too early");
  rd_launch_a: assert property ($fell(read_port_select_n) |-> ##[1:3] ($rose(k) && !read_port_select_n))
    else $error("read select not held over a k rise");
  wr_edges_a: assert property ($fell(write_port_select_n) |-> ##[1:3] ($rose(k) && !write_port_select_n) ##[1:4] $rose(k_n))
    else $error("write not framed by k then k_n rise");
  input_setup_a: assert property (($rose(k) || $rose(k_n)) |-> $stable(d) && $stable(addr) && $stable(byte_lane_write_mask_n))
    else $error("link inputs move at a sampling edge");
  rd_latency_a: assert property ($fell(read_port_select_n) && rd_gap >= 6'h18 && loop_disable_n |-> q_oe_n [*8] ##[6:14] $fell(q_oe_n))
    else $error("read data not on time");
  burst_len_a: assert property ($fell(q_oe_n) |-> !q_oe_n [*7])
    else $error("read burst shorter than two words");
  rd_float_a: assert property (rd_gap == 6'h20 |-> q_oe_n)
    else $error("read bus still driven after burst");
  echo_clock_a: assert property ($rose(c) |-> ##[1:5] $rose(returned_strobe))
    else $error("echo clock does not follow output clock");
  lock_early_a: assert property ($rose(loop_locked) |-> lock_cnt >= 12'(`LOCK_CYC))
    else $error("lock reported too early");
  lock_late_a: assert property (lock_cnt < 12'(LOCK_LATE))
    else $error("lock not reported in time");

  cover property ($fell(q_oe_n));
  cover property ($fell(read_port_select_n) && $fell(write_port_select_n));
  cover property ($fell(loop_locked));
endmodule
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench: controller end and device end joined by the link
`include "burst_sram_map.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        rd_req = 1'b0;
  logic [7:0]  rd_addr = 8'h00;
  logic        rd_ready;
  logic        rd_valid;
  logic [35:0] rd_data;
  logic        wr_req = 1'b0;
  logic [7:0]  wr_addr = 8'h00;
  logic [35:0] wr_data = 36'h0;
  logic [3:0]  wr_mask_n = 4'hf;
  logic        wr_ready;
  logic        loop_restart = 1'b0;
  logic        impedance_update;
  logic        single_clock_mode;
  logic        rd_req2 = 1'b0;
  logic        wr_req2 = 1'b0;
  logic        rd_ready2;
  logic        rd_valid2;
  logic [35:0] rd_data2;
  logic        wr_ready2;
  logic        single_mode2;
  logic [17:0] mem [512];
  int          error_cnt = 0;
  int          checks_done = 0;

  always #4 mclk = ~mclk;

  burst_sram_if #(.ADDR_W(8)) link ();
  sram_device_end #(.ADDR_W(8)) u_sram_device_end (
    .mclk(mclk), .rst_n(rst_n), .link(link.dev),
    .impedance_update(impedance_update), .single_clock_mode(single_clock_mode));
  sram_host_end #(.ADDR_W(8)) u_sram_host_end (
    .mclk(mclk), .rst_n(rst_n), .link(link.host),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_ready(rd_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_mask_n(wr_mask_n), .wr_ready(wr_ready), .loop_restart(loop_restart));
  // second pair: loop off and one clock pair, for the legacy timing
  burst_sram_if #(.ADDR_W(8)) link2 ();
  sram_device_end #(.ADDR_W(8)) u_sram_device_end_legacy (
    .mclk(mclk), .rst_n(rst_n), .link(link2.dev),
    .impedance_update(), .single_clock_mode(single_mode2));
  sram_host_end #(.ADDR_W(8), .SINGLE_CLOCK(1'b1), .LOOP_ON(1'b0)) u_sram_host_end_legacy (
    .mclk(mclk), .rst_n(rst_n), .link(link2.host),
    .rd_req(rd_req2), .rd_addr(rd_addr), .rd_ready(rd_ready2), .rd_valid(rd_valid2),
    .rd_data(rd_data2), .wr_req(wr_req2), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_mask_n(wr_mask_n), .wr_ready(wr_ready2), .loop_restart(loop_restart));
  burst_sram_chk #(.ADDR_W(8)) u_burst_sram_chk (
    .mclk(mclk), .rst_n(rst_n), .k(link.k), .k_n(link.k_n), .c(link.c),
    .read_port_select_n(link.read_port_select_n),
    .write_port_select_n(link.write_port_select_n),
    .loop_disable_n(link.loop_disable_n),
    .byte_lane_write_mask_n(link.byte_lane_write_mask_n), .addr(link.addr), .d(link.d),
    .q_oe_n(link.q_oe_n), .returned_strobe(link.returned_strobe),
    .loop_locked(link.loop_locked));

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic void model_write(logic [7:0] a, logic [35:0] wd, logic [3:0] wm);
    for (int i = 0; i < 4; i++)
      if (!wm[i]) mem[{a, i[1]}][i[0] * 9 +: 9] = wd[i * 9 +: 9];
  endfunction

  // each base address owns its own pair of words
  function automatic logic [35:0] model_read(logic [7:0] a);
    return {mem[{a, 1'b1}], mem[{a, 1'b0}]};
  endfunction

  // one read and/or one write taken at the same edge; the read waits for its data
  task automatic launch(input bit rd, input bit wr, input logic [7:0] ra, input logic [7:0] wa,
                        input logic [35:0] wd, input logic [3:0] wm, output logic [35:0] got);
    int n;
    n = 0;
    while (((rd && rd_ready !== 1'b1) || (wr && wr_ready !== 1'b1)) && n < 200) begin
      @(negedge mclk);
      n++;
    end
    rd_req = rd;
    rd_addr = ra;
    wr_req = wr;
    wr_addr = wa;
    wr_data = wd;
    wr_mask_n = wm;
    @(negedge mclk);
    rd_req = 1'b0;
    wr_req = 1'b0;
    if (wr) model_write(wa, wd, wm);
    while (rd && rd_valid !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    check(36'(n < 200), 36'h1);
    got = rd_data;
  endtask

  // lock time is counted from reset release, two cycles before this task starts
  task automatic t_lock();
    int n;
    n = 2;
    check({35'h0, link.q_oe_n}, 36'h1);
    check({18'h0, link.q_bus}, 36'h3ffff);
    check({35'h0, single_clock_mode}, 36'h0);
    while (link.loop_locked !== 1'b1 && n < 4000) begin
      @(negedge mclk);
      n++;
    end
    check(36'(n >= `LOCK_CYC && n < 4000), 36'h1);
  endtask

  task automatic t_basic();
    logic [35:0] got;
    launch(1'b0, 1'b1, 8'h10, 8'h10, 36'h123456789, 4'h0, got);
    launch(1'b1, 1'b0, 8'h10, 8'h10, 36'h0, 4'hf, got);
    check(got, model_read(8'h10));
  endtask

  task automatic t_masks();
    logic [35:0] got;
    launch(1'b0, 1'b1, 8'h20, 8'h20, 36'h0, 4'h0, got);
    for (int m = 0; m < 16; m++) begin
      launch(1'b0, 1'b1, 8'h20, 8'h20, {9{m[3:0]}}, 4'(m), got);
      launch(1'b1, 1'b0, 8'h20, 8'h20, 36'h0, 4'hf, got);
      check(got, model_read(8'h20));
    end
  endtask

  // odd base is a burst of its own; the read follows the write at once
  task automatic t_odd();
    logic [35:0] got;
    launch(1'b0, 1'b1, 8'h32, 8'h32, 36'hc3c3c3c3c, 4'h0, got);
    launch(1'b0, 1'b1, 8'h31, 8'h31, 36'h9a5a5a5a5, 4'h0, got);
    launch(1'b1, 1'b0, 8'h31, 8'h31, 36'h0, 4'hf, got);
    check(got, model_read(8'h31));
    launch(1'b1, 1'b0, 8'h32, 8'h32, 36'h0, 4'hf, got);
    check(got, model_read(8'h32));
  endtask

  // same burst on both pairs at one edge; the legacy pair answers half a cycle sooner
  task automatic t_legacy();
    int n;
    int n2;
    n = 0;
    n2 = 0;
    check({35'h0, single_mode2}, 36'h1);
    while ((wr_ready !== 1'b1 || wr_ready2 !== 1'b1) && n < 200) begin
      @(negedge mclk);
      n++;
    end
    wr_req = 1'b1;
    wr_req2 = 1'b1;
    wr_addr = 8'h60;
    wr_data = 36'h2468ace01;
    wr_mask_n = 4'h0;
    @(negedge mclk);
    wr_req = 1'b0;
    wr_req2 = 1'b0;
    model_write(8'h60, 36'h2468ace01, 4'h0);
    while ((rd_ready !== 1'b1 || rd_ready2 !== 1'b1) && n < 200) begin
      @(negedge mclk);
      n++;
    end
    rd_req = 1'b1;
    rd_req2 = 1'b1;
    rd_addr = 8'h60;
    @(negedge mclk);
    rd_req = 1'b0;
    rd_req2 = 1'b0;
    n = 0;
    while (rd_valid !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
      if (rd_valid2 === 1'b1) n2 = n;
    end
    check(36'(n < 200), 36'h1);
    check(rd_data, model_read(8'h60));
    check(rd_data2, model_read(8'h60));
    check(36'(n - n2), 36'(`K_HALF));
  endtask

  task automatic t_concurrent();
    logic [35:0] got;
    launch(1'b1, 1'b1, 8'h10, 8'h50, 36'h0f0f0f0f0, 4'h0, got);
    check(got, model_read(8'h10));
    launch(1'b1, 1'b1, 8'h50, 8'h50, 36'h5a5a5a5a5, 4'h0, got);
    check(got, model_read(8'h50));
  endtask

  task automatic t_imp();
    int n;
    n = 0;
    while (impedance_update !== 1'b1 && n < 9000) begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (impedance_update !== 1'b1 && n < 9000);
    check(36'(n), 36'(`ZQ_PERIOD * 2 * `K_HALF));
  endtask

  task automatic t_relock();
    logic [35:0] got;
    int n;
    n = 0;
    loop_restart = 1'b1;
    @(negedge mclk);
    loop_restart = 1'b0;
    while (link.loop_locked !== 1'b0 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    check({34'h0, link.k, link.k_n}, 36'h3);
    while (link.loop_locked !== 1'b1 && n < 4000) begin
      @(negedge mclk);
      n++;
    end
    check(36'(n >= `LOCK_CYC && n < 4000), 36'h1);
    launch(1'b1, 1'b0, 8'h50, 8'h50, 36'h0, 4'hf, got);
    check(got, model_read(8'h50));
  endtask

  // generous span: lock twice, two impedance periods and about fifty bursts
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    t_lock();
    t_basic();
    t_masks();
    t_odd();
    t_concurrent();
    t_legacy();
    t_imp();
    t_relock();
    tally_and_finish();
  end
endmodule
`default_nettype wire
